// ### rtl/pbwf_pkg.sv
package pbwf_pkg;
  // ==========================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CACHE_LINE_LENGTH = 8'h0c;
  localparam logic [7:0] ADDR_BRIDGE_CHIP_CONTROL = 8'h40;
  localparam logic [7:0] ADDR_FWD_CONTROL = 8'h80;
  localparam logic [7:0] ADDR_FWD_STATUS = 8'h84;
  // bridge_chip_control fields
  localparam int CHIP_DISC_CTRL_BIT = 0;
  localparam int CHIP_PF_DISABLE_BIT = 1;
  // fwd_control fields
  localparam int CTL_SERR_EN_BIT = 0;
  localparam int CTL_PRI_MTO_BIT = 1;
  localparam int CTL_SEC_MTO_BIT = 2;
  // Reset values
  localparam logic [7:0] CACHE_LINE_RESET = 8'h00;
  localparam logic [7:0] CHIP_CONTROL_RESET = 8'h00;
  localparam logic [2:0] FWD_CONTROL_RESET = 3'h0;
  // ==========================================
  // Counts
  localparam int ATTEMPT_LIMIT = 1 << 24;
  localparam int DISCARD_LONG_CLKS = 1 << 15;
  localparam int DISCARD_SHORT_CLKS = 1 << 10;
  localparam int POST_DEPTH_DW = 32;
  localparam int MWI_FREE_MIN_DW = 8;
  localparam int PAGE_DW = 1024;
  localparam int LINE16_DW = 16;
  localparam int DQ_DEPTH = 4;
  // ==========================================
  // PCI commands
  localparam logic [3:0] CMD_IO_READ = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE = 4'h3;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_READ = 4'ha;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
  localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;
  localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
  localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hf;
  // Target response to a data phase
  typedef enum logic [2:0] {
    RESP_NONE = 3'b000,
    RESP_RETRY = 3'b001,
    RESP_DATA = 3'b010,
    RESP_DATA_DISC = 3'b011,
    RESP_ABORT = 3'b100
  } pbwf_resp_t;
  // Delayed entry state
  typedef enum logic [1:0] {
    DQ_FREE = 2'b00,
    DQ_PENDING = 2'b01,
    DQ_DONE = 2'b10,
    DQ_FAILED = 2'b11
  } pbwf_dq_t;
endpackage

// ### rtl/pbwf_forward_ctrl.sv
// Function
// - I/O and type 1 config writes go delayed, one Dword only
// - First delayed write is claimed then retried
// - Capture command, address, parity, then data, enables, data parity
// - Queue new entry only with room and no same address/command entry
// - Head entry is written to target, retried until done or error
// - After 2^24 failed attempts remove entry, abort initiator, raise error
// - System error output only when fwd_control enable bit set
// - Completed head repeat gets TRDY, plus STOP if multiple Dwords
// - Repeat compare ignores bytes whose enables are high
// - Early repeat gets retry and makes no new entry
// - Discard timer at head of completed entry; expiry drops, errors
// - Memory write disconnects at 4 kB when control bit 0
// - Memory write disconnects at nth line when control bit 1
// - Memory write and invalidate never crosses 4 kB
// - MWI 16-Dword lines disconnect at every 16-Dword boundary
// - Posted writes accepted while a Dword free; full gives disconnect; here a new write is retried below 8 Dwords free
// - Delayed writes accepted whenever a delayed entry is free
// - Fast back-to-back writes retried when short of space; no merging
// - Every read forwarded delayed, prefetchable or not
// - Unconsumed prefetched data discarded when master ends read
// - I/O and config reads never prefetched; line/multiple always
// - Downstream read prefetch if in range; upstream unless disabled
// - Cache line length counts Dwords per line
// - Invalid line length turns MWI into plain write, no lines
module pbwf_forward_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Target side: decoded transaction start and data phases
  input wire logic tgt_start,
  input wire logic tgt_upstream,
  input wire logic tgt_fast_b2b,
  input wire logic [3:0] tgt_cmd,
  input wire logic [31:0] tgt_addr,
  input wire logic tgt_addr_par,
  input wire logic tgt_irdy,
  input wire logic tgt_last,
  input wire logic [31:0] tgt_data,
  input wire logic [3:0] tgt_be_n,
  input wire logic tgt_data_par,
  input wire logic tgt_in_pf_range,
  input wire logic tgt_read_end,
  output logic tgt_devsel,
  output pbwf_pkg::pbwf_resp_t tgt_resp,
  output logic tgt_mwi_as_mw,
  output logic rd_prefetch,
  output logic rd_discard,
  // Posted buffer
  input wire logic [5:0] post_free_dw,
  output logic post_push,
  output logic [31:0] post_data,
  // Delayed write delivery on target bus
  output logic dw_req,
  output logic [3:0] dw_cmd,
  output logic [31:0] dw_addr,
  output logic [31:0] dw_data,
  output logic [3:0] dw_be_n,
  input wire logic dw_done,
  input wire logic dw_retry,
  input wire logic dw_error,
  // Error output
  output logic primary_system_error_out
);
  import pbwf_pkg::*;

  typedef struct packed {
    logic [3:0] cmd;
    logic [31:0] addr;
    logic apar;
    logic [31:0] data;
    logic [3:0] be_n;
    logic dpar;
  } pbwf_entry_t;

  typedef struct packed {
    logic [7:0] line_length_dwords;
    logic [7:0] chip;
    logic [2:0] ctl;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    pbwf_dq_t [DQ_DEPTH-1:0] dq_st;
    pbwf_entry_t [DQ_DEPTH-1:0] dq;
    logic [1:0] head;
    logic [1:0] tail;
    logic [24:0] attempts;
    logic [15:0] discard;
    logic in_xfer;
    logic xfer_delayed;
    logic xfer_match;
    logic xfer_post;
    logic [1:0] xfer_idx;
    logic [3:0] cmd;
    logic [9:0] dw_off;
    logic [31:0] cur_addr;
    logic got_first;
    logic fail_flag;
    logic [2:0] tresp;
    logic serr;
    logic rd_pf;
    logic rd_disc;
    logic push;
    logic [31:0] pdata;
  } pbwf_state_t;

  pbwf_state_t s_r, s_nxt;

  logic cls_valid, is_delayed_cmd, dq_room, dup_found, match_head;
  logic [7:0] cls_m1;
  logic at_line, at_page, at_16, want_disc;
  logic [1:0] dup_idx;
  logic [31:0] be_mask;
  pbwf_entry_t hd;

  always_comb begin
    cls_m1 = 8'(s_r.line_length_dwords - 8'h01);
    // Line length counts Dwords; must be a nonzero power of two up to 16
    cls_valid = (s_r.line_length_dwords != 8'h00) && ((s_r.line_length_dwords & cls_m1) == 8'h00) && (s_r.line_length_dwords <= 8'h10);
    is_delayed_cmd = (tgt_cmd == CMD_IO_WRITE) || (tgt_cmd == CMD_CFG_WRITE);
    dq_room = (s_r.dq_st[s_r.tail] == DQ_FREE);
    dup_found = 1'b0;
    dup_idx = 2'd0;
    for (int i = 0; i < DQ_DEPTH; i++) begin
      if (s_r.dq_st[i] != DQ_FREE && s_r.dq[i].cmd == tgt_cmd && s_r.dq[i].addr == tgt_addr) begin
        dup_found = 1'b1;
        dup_idx = 2'(i);
      end
    end
    hd = s_r.dq[s_r.head];
    // Only enabled bytes take part in the repeat compare
    be_mask = {{8{~tgt_be_n[3]}}, {8{~tgt_be_n[2]}}, {8{~tgt_be_n[1]}}, {8{~tgt_be_n[0]}}};
    match_head = (hd.cmd == s_r.cmd) && (hd.addr == s_r.cur_addr) && (hd.be_n == tgt_be_n)
                 && (((hd.data ^ tgt_data) & be_mask) == 32'h0);
    at_line = ((s_r.dw_off + 10'd1) & 10'(cls_m1)) == 10'h0;
    at_page = (s_r.dw_off == 10'(PAGE_DW - 1));
    at_16 = ((s_r.dw_off + 10'd1) & 10'(LINE16_DW - 1)) == 10'h0;
    want_disc = 1'b0;
    if (s_r.cmd == CMD_MEM_WRITE_INV && cls_valid) begin
      if (s_r.line_length_dwords == 8'(LINE16_DW)) begin
        want_disc = at_16 || at_page;
      end else begin
        want_disc = at_page || (at_line && (post_free_dw < 6'(MWI_FREE_MIN_DW + 1)));
      end
    end else if (s_r.chip[CHIP_DISC_CTRL_BIT] && cls_valid) begin
      want_disc = at_line || at_page;
    end else begin
      want_disc = at_page;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.tresp = RESP_NONE;
    s_nxt.push = 1'b0;
    s_nxt.serr = 1'b0;
    s_nxt.rd_disc = tgt_read_end;
    // ==========================================
    // AHB-Lite slave, zero wait, always OKAY
    if (s_r.ap_valid && s_r.ap_write) begin
      case (s_r.ap_addr)
        ADDR_CACHE_LINE_LENGTH: s_nxt.line_length_dwords = hwdata[7:0];
        ADDR_BRIDGE_CHIP_CONTROL: s_nxt.chip = hwdata[7:0];
        ADDR_FWD_CONTROL: s_nxt.ctl = hwdata[2:0];
        default: ;
      endcase
    end
    // Writes above the first 256 bytes must not alias onto the map
    s_nxt.ap_valid = hsel && hready && htrans[1] && (hsize == 3'b010) && (haddr[31:8] == 24'h0);
    s_nxt.ap_write = hwrite;
    s_nxt.ap_addr = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite && haddr[31:8] == 24'h0) begin
      case (haddr[7:0])
        ADDR_CACHE_LINE_LENGTH: s_nxt.rdata = {24'h0, s_r.line_length_dwords};
        ADDR_BRIDGE_CHIP_CONTROL: s_nxt.rdata = {24'h0, s_r.chip};
        ADDR_FWD_CONTROL: s_nxt.rdata = {29'h0, s_r.ctl};
        ADDR_FWD_STATUS: s_nxt.rdata = {21'h0, s_r.fail_flag, s_r.dq_st[s_r.head],
                                        s_r.head, s_r.tail, 2'h0, s_r.in_xfer, s_r.xfer_delayed};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    // ==========================================
    // Target side decisions
    // A new address phase abandons whatever transfer was still open
    if (tgt_start) begin
      s_nxt.cmd = tgt_cmd;
      s_nxt.cur_addr = tgt_addr;
      s_nxt.dw_off = tgt_addr[11:2];
      s_nxt.got_first = 1'b0;
      s_nxt.in_xfer = 1'b0;
      s_nxt.xfer_delayed = 1'b0;
      s_nxt.xfer_post = 1'b0;
      s_nxt.xfer_match = 1'b0;
      if (is_delayed_cmd) begin
        s_nxt.in_xfer = 1'b1;
        s_nxt.xfer_delayed = 1'b1;
        if (dup_found) begin
          s_nxt.xfer_match = 1'b1;
          s_nxt.xfer_idx = dup_idx;
        end else if (dq_room && !(tgt_fast_b2b && !dq_room)) begin
          // Address phase captured in the cycle it stands
          s_nxt.dq[s_r.tail].cmd = tgt_cmd;
          s_nxt.dq[s_r.tail].addr = tgt_addr;
          s_nxt.dq[s_r.tail].apar = tgt_addr_par;
          s_nxt.xfer_idx = s_r.tail;
        end else begin
          s_nxt.xfer_idx = 2'd0;
          s_nxt.xfer_match = 1'b1;
        end
      end else if (tgt_cmd == CMD_MEM_WRITE || tgt_cmd == CMD_MEM_WRITE_INV) begin
        s_nxt.in_xfer = 1'b1;
        s_nxt.xfer_post = 1'b1;
        // Too little room for a burst start: retry rather than accept a stub
        if (post_free_dw < 6'(MWI_FREE_MIN_DW)) begin
          s_nxt.in_xfer = 1'b0;
          s_nxt.tresp = RESP_RETRY;
        end
      end else begin
        // Reads: delayed, classified for prefetch
        case (tgt_cmd)
          CMD_MEM_READ_LINE, CMD_MEM_READ_MULT: s_nxt.rd_pf = 1'b1;
          CMD_MEM_READ: s_nxt.rd_pf = tgt_upstream ? !s_r.chip[CHIP_PF_DISABLE_BIT]
                                                   : tgt_in_pf_range;
          default: s_nxt.rd_pf = 1'b0;
        endcase
      end
    end else if (s_r.in_xfer && tgt_irdy) begin
      if (s_r.xfer_delayed) begin
        s_nxt.in_xfer = 1'b0;
        if (!s_r.xfer_match) begin
          // First data, enables and parity into the new entry
          s_nxt.dq[s_r.xfer_idx].data = tgt_data;
          s_nxt.dq[s_r.xfer_idx].be_n = tgt_be_n;
          s_nxt.dq[s_r.xfer_idx].dpar = tgt_data_par;
          s_nxt.dq_st[s_r.xfer_idx] = DQ_PENDING;
          s_nxt.tail = 2'(s_r.tail + 2'd1);
          s_nxt.tresp = RESP_RETRY;
        end else if (s_r.xfer_idx == s_r.head && match_head && s_r.dq_st[s_r.head] == DQ_DONE) begin
          s_nxt.tresp = tgt_last ? RESP_DATA : RESP_DATA_DISC;
          s_nxt.dq_st[s_r.head] = DQ_FREE;
          s_nxt.head = 2'(s_r.head + 2'd1);
        end else if (s_r.xfer_idx == s_r.head && match_head && s_r.dq_st[s_r.head] == DQ_FAILED) begin
          s_nxt.tresp = RESP_ABORT;
          s_nxt.dq_st[s_r.head] = DQ_FREE;
          s_nxt.head = 2'(s_r.head + 2'd1);
        end else begin
          s_nxt.tresp = RESP_RETRY;
        end
      end else if (s_r.xfer_post) begin
        // Each data phase is its own push; separate writes never merge
        s_nxt.push = 1'b1;
        s_nxt.pdata = tgt_data;
        s_nxt.dw_off = 10'(s_r.dw_off + 10'd1);
        if (post_free_dw <= 6'd1 || want_disc) begin
          s_nxt.tresp = RESP_DATA_DISC;
          s_nxt.in_xfer = 1'b0;
        end else begin
          s_nxt.tresp = RESP_DATA;
          s_nxt.in_xfer = !tgt_last;
        end
      end
    end
    // ==========================================
    // Delivery of head entry on target bus
    if (s_r.dq_st[s_r.head] == DQ_PENDING) begin
      if (dw_done) begin
        s_nxt.dq_st[s_r.head] = DQ_DONE;
        s_nxt.attempts = 25'h0;
        // The timer expires on the cycle after it reads zero, so load one less
        s_nxt.discard = s_r.ctl[tgt_upstream ? CTL_SEC_MTO_BIT : CTL_PRI_MTO_BIT]
                        ? 16'(DISCARD_SHORT_CLKS - 1) : 16'(DISCARD_LONG_CLKS - 1);
      end else if (dw_retry) begin
        s_nxt.attempts = 25'(s_r.attempts + 25'd1);
        if (s_r.attempts == 25'(ATTEMPT_LIMIT - 1) || dw_error) begin
          s_nxt.dq_st[s_r.head] = DQ_FAILED;
          s_nxt.attempts = 25'h0;
          s_nxt.fail_flag = 1'b1;
          s_nxt.serr = s_r.ctl[CTL_SERR_EN_BIT];
        end
      end else if (dw_error) begin
        // A hard error ends delivery just as the attempt limit does
        s_nxt.dq_st[s_r.head] = DQ_FAILED;
        s_nxt.attempts = 25'h0;
        s_nxt.fail_flag = 1'b1;
        s_nxt.serr = s_r.ctl[CTL_SERR_EN_BIT];
      end
    end else if (s_r.dq_st[s_r.head] == DQ_DONE && s_nxt.dq_st[s_r.head] == DQ_DONE) begin
      if (s_r.discard == 16'h0) begin
        s_nxt.dq_st[s_r.head] = DQ_FREE;
        s_nxt.head = 2'(s_r.head + 2'd1);
        s_nxt.serr = s_r.ctl[CTL_SERR_EN_BIT];
      end else begin
        s_nxt.discard = 16'(s_r.discard - 16'd1);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.line_length_dwords <= CACHE_LINE_RESET;
      s_r.chip <= CHIP_CONTROL_RESET;
      s_r.ctl <= FWD_CONTROL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign tgt_devsel = s_r.tresp != RESP_NONE;
  assign tgt_resp = pbwf_resp_t'(s_r.tresp);
  assign tgt_mwi_as_mw = !cls_valid;
  assign rd_prefetch = s_r.rd_pf;
  assign rd_discard = s_r.rd_disc;
  assign post_push = s_r.push;
  assign post_data = s_r.pdata;
  // Only the head entry is ever offered to the target bus
  assign dw_req = s_r.dq_st[s_r.head] == DQ_PENDING;
  assign dw_cmd = hd.cmd;
  assign dw_addr = hd.addr;
  assign dw_data = hd.data;
  assign dw_be_n = hd.be_n;
  assign primary_system_error_out = s_r.serr;
endmodule

// ### tb/pbwf_sva.sv
module pbwf_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Target side
  input wire logic tgt_start,
  input wire logic tgt_upstream,
  input wire logic [3:0] tgt_cmd,
  input wire logic tgt_in_pf_range,
  input wire logic tgt_irdy,
  input wire logic tgt_read_end,
  input wire logic [5:0] post_free_dw,
  input wire logic tgt_devsel,
  input wire pbwf_pkg::pbwf_resp_t tgt_resp,
  input wire logic rd_prefetch,
  input wire logic rd_discard,
  input wire logic post_push,
  // Delivery and error
  input wire logic dw_req,
  input wire logic [31:0] dw_addr,
  input wire logic [31:0] dw_data,
  input wire logic dw_done,
  input wire logic dw_retry,
  input wire logic dw_error,
  input wire logic primary_system_error_out
);
  import pbwf_pkg::*;
  // ==========================================
  // Helper: open transaction is a posted one
  logic posted_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      posted_r <= 1'h0;
    end else if (tgt_start) begin
      posted_r <= (tgt_cmd == CMD_MEM_WRITE) || (tgt_cmd == CMD_MEM_WRITE_INV);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================
  // Assertions
  a_devsel_with_resp: assert property (tgt_resp != RESP_NONE |-> tgt_devsel)
    else $error("response without device select");
  a_discard_after_end: assert property (tgt_read_end |-> ##[1:2] rd_discard)
    else $error("leftover read data not discarded");
  a_never_prefetch: assert property (tgt_start && (tgt_cmd == CMD_IO_READ ||
    tgt_cmd == CMD_CFG_READ) |=> !rd_prefetch) else $error("io or config read prefetched");
  a_always_prefetch: assert property (tgt_start && (tgt_cmd == CMD_MEM_READ_LINE ||
    tgt_cmd == CMD_MEM_READ_MULT) |=> rd_prefetch) else $error("line read not prefetched");
  a_down_range: assert property (tgt_start && tgt_cmd == CMD_MEM_READ && !tgt_upstream
    |=> rd_prefetch == $past(tgt_in_pf_range)) else $error("downstream prefetch wrong");
  a_delayed_no_post: assert property (post_push |-> posted_r)
    else $error("delayed write pushed into posted buffer");
  a_full_disc: assert property (posted_r && tgt_irdy && post_free_dw <= 6'h01
    |-> ##[1:2] tgt_resp == RESP_DATA_DISC) else $error("full buffer without disconnect");
  a_head_holds: assert property (dw_req && !(dw_done || dw_retry || dw_error)
    |=> dw_req && $stable(dw_addr) && $stable(dw_data)) else $error("head entry dropped");
  a_error_pulse: assert property (primary_system_error_out |=> !primary_system_error_out)
    else $error("system error longer than one cycle");
  c_disconnect: cover property (tgt_resp == RESP_DATA_DISC);
  c_far_retry: cover property (dw_retry);
  c_error: cover property (primary_system_error_out);
endmodule

bind pbwf_forward_ctrl pbwf_sva pbwf_sva_inst (.clock, .rst, .tgt_start, .tgt_upstream,
  .tgt_cmd, .tgt_in_pf_range, .tgt_irdy, .tgt_read_end, .post_free_dw, .tgt_devsel, .tgt_resp,
  .rd_prefetch, .rd_discard, .post_push, .dw_req, .dw_addr, .dw_data, .dw_done, .dw_retry,
  .dw_error, .primary_system_error_out);

// ### tb/pbwf_far_target.sv
module pbwf_far_target (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bench control: hold off, retries before success
  input wire logic stall,
  input wire logic [3:0] retries,
  // Delivery port
  input wire logic dw_req,
  output logic dw_done,
  output logic dw_retry,
  output logic dw_error
);
  logic [3:0] tries_r;
  // No error case is commanded; an idle cycle between answers models a slow target
  assign dw_error = 1'h0;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dw_done <= 1'h0;
      dw_retry <= 1'h0;
      tries_r <= 4'h0;
    end else begin
      dw_done <= 1'h0;
      dw_retry <= 1'h0;
      if (dw_req && !stall && !dw_done && !dw_retry) begin
        dw_retry <= tries_r < retries;
        dw_done <= tries_r >= retries;
        tries_r <= (tries_r < retries) ? tries_r + 4'h1 : 4'h0;
      end
    end
  end
endmodule

// ### tb/pci_bridge_write_forwarding_test.sv
module pci_bridge_write_forwarding_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pbwf_pkg::*;
  typedef struct {logic [3:0] c; logic [31:0] a; logic up; logic rng; int np;
    pbwf_resp_t r; int n; logic pf;} pbwf_row_t;
  logic clock = 1'h0, rst = 1'h1, hwrite = 1'h0, tgt_start = 1'h0, tgt_upstream = 1'h0;
  logic tgt_irdy = 1'h0, tgt_last = 1'h0, tgt_in_pf_range = 1'h0, tgt_read_end = 1'h0;
  logic stall = 1'h0, hready, hresp, tgt_devsel, tgt_mwi_as_mw, rd_prefetch, rd_discard;
  logic post_push, dw_req, dw_done, dw_retry, dw_error, primary_system_error_out;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, tgt_addr = 32'h0, tgt_data = 32'h0;
  logic [31:0] hrdata, dw_addr, dw_data, rd, post_data;
  logic [3:0] dw_cmd, dw_be_n;
  logic [1:0] htrans = 2'h0;
  logic [3:0] tgt_cmd = 4'h0, tgt_be_n = 4'h0, retries = 4'h0;
  logic [5:0] post_free_dw = 6'h20;
  pbwf_resp_t tgt_resp, r;
  int errors = 0, cmp_count = 0, cyc = 0, n, k;
  logic [7:0] ra[4] = '{ADDR_CACHE_LINE_LENGTH, ADDR_BRIDGE_CHIP_CONTROL, ADDR_FWD_CONTROL, 8'h90};
  pbwf_row_t rows[11] = '{
    '{CMD_IO_READ, 32'h0, 1'h0, 1'h1, 0, RESP_NONE, 0, 1'h0},
    '{CMD_CFG_READ, 32'h0, 1'h0, 1'h1, 0, RESP_NONE, 0, 1'h0},
    '{CMD_MEM_READ, 32'h0, 1'h0, 1'h1, 0, RESP_NONE, 0, 1'h1},
    '{CMD_MEM_READ, 32'h0, 1'h0, 1'h0, 0, RESP_NONE, 0, 1'h0},
    '{CMD_MEM_READ, 32'h0, 1'h1, 1'h0, 0, RESP_NONE, 0, 1'h1},
    '{CMD_MEM_READ_LINE, 32'h0, 1'h0, 1'h0, 0, RESP_NONE, 0, 1'h1},
    '{CMD_MEM_READ_MULT, 32'h0, 1'h1, 1'h0, 0, RESP_NONE, 0, 1'h1},
    '{CMD_MEM_WRITE, 32'hff8, 1'h0, 1'h0, 4, RESP_DATA_DISC, 2, 1'h0},
    '{CMD_MEM_WRITE_INV, 32'h0, 1'h0, 1'h0, 20, RESP_DATA_DISC, 16, 1'h0},
    '{CMD_MEM_WRITE, 32'h0, 1'h0, 1'h0, 40, RESP_DATA_DISC, 32, 1'h0},
    '{CMD_MEM_WRITE, 32'h40, 1'h0, 1'h0, 3, RESP_DATA, 3, 1'h0}};
  // ==========================================
  // Design, far target, clock
  pbwf_forward_ctrl pbwf_forward_ctrl_inst (.clock, .rst, .hsel(1'h1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hready, .hwdata, .hrdata, .hreadyout(hready), .hresp, .tgt_start,
    .tgt_upstream, .tgt_fast_b2b(1'h0), .tgt_cmd, .tgt_addr, .tgt_addr_par(1'h0), .tgt_irdy,
    .tgt_last, .tgt_data, .tgt_be_n, .tgt_data_par(1'h0), .tgt_in_pf_range, .tgt_read_end,
    .tgt_devsel, .tgt_resp, .tgt_mwi_as_mw, .rd_prefetch, .rd_discard, .post_free_dw,
    .post_push, .post_data, .dw_req, .dw_cmd, .dw_addr, .dw_data, .dw_be_n, .dw_done,
    .dw_retry, .dw_error, .primary_system_error_out);
  pbwf_far_target pbwf_far_target_inst (.clock, .rst, .stall, .retries, .dw_req, .dw_done,
    .dw_retry, .dw_error);
  always #5 clock = ~clock;
  // ==========================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input pbwf_resp_t got, exp);
    chk({29'h0, got}, {29'h0, exp});
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      errors++;
      complete_run;
    end
  end
  // ==========================================
  // Bus cycles
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clock); while (!hready);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (!hready);
    rd = hrdata;
  endtask
  // Gaps between data phases keep each answer tied to its own phase
  task automatic xfer(input logic [3:0] c, input logic [31:0] a, d, input logic [3:0] be,
      input int np, input logic up, rng);
    int w;
    tgt_cmd <= c;
    tgt_addr <= a;
    tgt_data <= d;
    tgt_be_n <= be;
    tgt_upstream <= up;
    tgt_in_pf_range <= rng;
    post_free_dw <= 6'h20;
    tgt_start <= 1'h1;
    @(posedge clock);
    tgt_start <= 1'h0;
    r = RESP_DATA;
    for (n = 0; n < np && r === RESP_DATA; n++) begin
      tgt_irdy <= 1'h1;
      tgt_last <= 1'(n == np - 1);
      post_free_dw <= 6'(32 - n);
      @(posedge clock);
      tgt_irdy <= 1'h0;
      r = RESP_NONE;
      for (w = 0; w < 4 && r === RESP_NONE; w++) begin
        @(negedge clock);
        r = tgt_resp;
        if (post_push === 1'h1) chk(post_data, d);
      end
      @(posedge clock);
    end
  endtask
  task automatic rdchk(input logic [3:0] c, input logic up, rng, pf);
    xfer(c, 32'h0, 32'h0, 4'h0, 0, up, rng);
    @(posedge clock);
    chk({31'h0, rd_prefetch}, {31'h0, pf});
    tgt_read_end <= 1'h1;
    @(posedge clock);
    tgt_read_end <= 1'h0;
  endtask
  task automatic idle;
    int w;
    for (w = 0; w < 200 && dw_req !== 1'h0; w++) @(posedge clock);
    chk({31'h0, dw_req}, 32'h0);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    foreach (ra[i]) begin
      ahb(1'h0, ra[i], 32'h0);
      chk(rd, 32'h0);
      ahb(1'h1, ra[i], 32'h3);
      ahb(1'h0, ra[i], 32'h0);
      chk(rd, (i == 3) ? 32'h0 : 32'h3);
    end
    chk({31'h0, tgt_mwi_as_mw}, 32'h1);
    ahb(1'h1, ADDR_CACHE_LINE_LENGTH, 32'h10);
    ahb(1'h1, ADDR_BRIDGE_CHIP_CONTROL, 32'h0);
    ahb(1'h1, ADDR_FWD_CONTROL, 32'h1);
    chk({31'h0, tgt_mwi_as_mw}, 32'h0);
    stall <= 1'h1;
    retries <= 4'h3;
    xfer(CMD_IO_WRITE, 32'h100, 32'h1234_5678, 4'h1, 1, 1'h0, 1'h0);
    chkr(r, RESP_RETRY);
    xfer(CMD_IO_WRITE, 32'h100, 32'h1234_5678, 4'h1, 1, 1'h0, 1'h0);
    chkr(r, RESP_RETRY);
    chk({28'h0, dw_be_n}, 32'h1);
    chk({28'h0, dw_cmd}, {28'h0, CMD_IO_WRITE});
    ahb(1'h0, ADDR_FWD_STATUS, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h1);
    chk(dw_addr, 32'h100);
    chk(dw_data, 32'h1234_5678);
    stall <= 1'h0;
    idle;
    xfer(CMD_IO_WRITE, 32'h100, 32'h1234_56ff, 4'h1, 1, 1'h0, 1'h0);
    chkr(r, RESP_DATA);
    retries <= 4'h0;
    xfer(CMD_CFG_WRITE, 32'h200, 32'h0, 4'h0, 1, 1'h0, 1'h0);
    chkr(r, RESP_RETRY);
    idle;
    xfer(CMD_CFG_WRITE, 32'h200, 32'h0, 4'h0, 2, 1'h0, 1'h0);
    chkr(r, RESP_DATA_DISC);
    ahb(1'h1, ADDR_FWD_CONTROL, 32'h7);
    xfer(CMD_IO_WRITE, 32'h300, 32'h0, 4'h0, 1, 1'h0, 1'h0);
    idle;
    for (k = 0; k < 1200 && primary_system_error_out !== 1'h1; k++) @(posedge clock);
    chk({31'h0, k > 1000 && k < 1100}, 32'h1);
    xfer(CMD_IO_WRITE, 32'h300, 32'h0, 4'h0, 1, 1'h0, 1'h0);
    chkr(r, RESP_RETRY);
    idle;
    ahb(1'h1, ADDR_FWD_CONTROL, 32'h6);
    for (k = 0; k < 1100 && primary_system_error_out !== 1'h1; k++) @(posedge clock);
    chk({31'h0, primary_system_error_out}, 32'h0);
    ahb(1'h0, ADDR_FWD_STATUS, 32'h0);
    chk({30'h0, rd[9:8]}, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].np == 0) begin
        rdchk(rows[i].c, rows[i].up, rows[i].rng, rows[i].pf);
      end else begin
        xfer(rows[i].c, rows[i].a, 32'h5a5a_0000, 4'h0, rows[i].np, 1'h0, 1'h0);
        chkr(r, rows[i].r);
        chk(32'(n), 32'(rows[i].n));
      end
    end
    ahb(1'h1, ADDR_BRIDGE_CHIP_CONTROL, 32'h2);
    rdchk(CMD_MEM_READ, 1'h1, 1'h0, 1'h0);
    complete_run;
  end
endmodule
